// ### design/tbdp_top.sv
`timescale 1ns/100ps
module tbdp_top
  import tbdp_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Core trace side
  input  wire tbdp_event_e core_event,
  input  wire tbdp_mode_e  core_mode,
  input  wire logic        core_address_gen_execute_stage_first,
  input  wire logic [1:0]  branch_addr_bytes_m1,
  input  wire logic        cap_valid,
  input  wire tbdp_capture_s cap_data,
  output logic             core_stall,
  output logic [3:0]       exec_status_nibble,
  output logic [3:0]       debug_value_nibble,
  // Serial pins
  input  wire logic        host_serial_clock,
  input  wire logic        host_serial_in,
  output logic             host_serial_out,
  // Command side towards core/memory
  output logic             cmd_valid,
  output tbdp_cmd_s        cmd_data,
  input  wire logic        cmd_done,
  input  wire logic        cmd_bus_error,
  input  wire logic [31:0] cmd_rdata,
  input  wire logic [15:0] cmd_wdata_unused
);
  initial begin
    if (FIFO_DEPTH < TBDP_FIFO_D) $error("tbdp_top: fifo too shallow");
  end

  // ****************************************
  // Capture buffer, two words deep on the core
  // ****************************************
  logic                 cap_in_ready;
  logic                 buf_valid;
  logic                 buf_take;
  tbdp_capture_s        buf_word;
  logic [TBDP_CAP_W-1:0] buf_raw;
  logic [1:0]           held_q;
  logic                 cap_push;

  // Core sees only two entries; the deeper fifo never blocks before that
  assign cap_push   = cap_valid && !core_stall;
  assign core_stall = (held_q == 2'd2) && !buf_take;

  tbdp_fifo #(.WIDTH(TBDP_CAP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_valid  (cap_push),
    .in_ready  (cap_in_ready),
    .in_data   (cap_data),
    .out_valid (buf_valid),
    .out_ready (buf_take),
    .out_data  (buf_raw)
  );
  assign buf_word = tbdp_capture_s'(buf_raw);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) held_q <= 2'd0;
    else held_q <= held_q + 2'(cap_push && cap_in_ready) - 2'(buf_take);
  end

  // ****************************************
  // Nibble shifter
  // ****************************************
  logic [31:0] shift_q;
  logic [3:0]  nib_left_q;
  logic        announce_q;
  logic [1:0]  ann_cnt_q;

  // Announce cycle takes the word, then its nibbles follow
  // Only in run mode, so the count code is never hidden by a mode code
  assign buf_take = buf_valid && !announce_q && (nib_left_q <= 4'd1) && (core_mode == TBDP_MD_RUN);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift_q            <= '0;
      nib_left_q         <= '0;
      announce_q         <= 1'b0;
      ann_cnt_q          <= '0;
      debug_value_nibble <= '0;
    end else begin
      announce_q <= buf_take;
      if (buf_take) begin
        ann_cnt_q <= buf_word.nbytes_m1;
      end
      if (announce_q) begin
        debug_value_nibble <= shift_q[3:0];
        shift_q            <= {4'h0, shift_q[31:4]};
        nib_left_q         <= nib_left_q - 4'd1;
      end else if (nib_left_q > 4'd1) begin
        debug_value_nibble <= shift_q[3:0];
        shift_q            <= {4'h0, shift_q[31:4]};
        nib_left_q         <= nib_left_q - 4'd1;
      end else begin
        nib_left_q <= '0;
      end
      if (buf_take) begin
        // Two nibbles per byte plus the announce cycle
        shift_q    <= buf_word.value;
        nib_left_q <= {1'b0, buf_word.nbytes_m1, 1'b0} + 4'd3;
      end
    end
  end

  // ****************************************
  // Status nibble
  // ****************************************
  logic [3:0] st_d;
  logic [3:0] ev_code;
  assign ev_code =
    !core_address_gen_execute_stage_first               ? TBDP_ST_CONT   :
    core_event == TBDP_EV_INSTR    ? TBDP_ST_INSTR  :
    core_event == TBDP_EV_USER     ? TBDP_ST_USER   :
    core_event == TBDP_EV_MARK     ? TBDP_ST_MARK   :
    core_event == TBDP_EV_BRANCH   ? TBDP_ST_BRANCH :
    core_event == TBDP_EV_RETEX    ? TBDP_ST_RETEX  : TBDP_ST_CONT;

  assign st_d =
    core_mode == TBDP_MD_HALT ? TBDP_ST_HALT :
    core_mode == TBDP_MD_STOP ? TBDP_ST_STOP :
    core_mode == TBDP_MD_EMU  ? TBDP_ST_EMU  :
    core_mode == TBDP_MD_EXC  ? TBDP_ST_EXC  :
    buf_take                  ? {2'b10, buf_word.nbytes_m1} :
    ev_code;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) exec_status_nibble <= TBDP_ST_CONT;
    else exec_status_nibble <= st_d;
  end

  // ****************************************
  // Serial port: pin synchronisers
  // ****************************************
  logic [1:0] sclk_sync_q;
  logic [1:0] sin_sync_q;
  logic       sclk_prev_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_sync_q <= '0;
      sin_sync_q  <= '0;
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], host_serial_clock};
      sin_sync_q  <= {sin_sync_q[0], host_serial_in};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end
  wire sclk_rise = sclk_sync_q[1] && !sclk_prev_q;

  // ****************************************
  // Serial shift and command engine
  // ****************************************
  logic [16:0] rx_q;
  logic [16:0] tx_q;
  logic [4:0]  bit_q;
  logic        busy_q;
  logic        berr_q;
  logic [31:0] rdata_q;
  tbdp_resp_e  resp_q;
  logic        halted;
  logic        done_pend_q;
  logic        cmd_is_wr;
  logic [16:0] rsp_word;
  logic [16:0] tx_src;
  logic [15:0] rx_word;
  logic [3:0]  rx_op;
  logic        is_reg_cmd;
  logic        is_illegal;
  logic [31:0] aligned_addr;
  logic [1:0]  rx_size;

  assign halted     = (core_mode == TBDP_MD_HALT);
  assign rx_word    = {rx_q[14:0], sin_sync_q[1]};
  assign rx_op      = rx_word[15:12];
  assign rx_size    = rx_word[11:10];
  assign is_reg_cmd = (rx_op == TBDP_OP_RD_CTL) || (rx_op == TBDP_OP_WR_CTL);
  assign is_illegal = (rx_op == TBDP_OP_CALL) || (rx_op == TBDP_OP_RST) ||
                      (rx_op == TBDP_OP_FILL && !halted) || (rx_op == TBDP_OP_DUMP && !halted) ||
                      (is_reg_cmd && !halted) || (rx_op == 4'h0) || (rx_op > TBDP_OP_RST);
  // Address is carried by the command word low bits here, forced aligned
  assign aligned_addr = (rx_size == TBDP_SZ_LONG) ? {22'h0, rx_word[9:2], 2'b00} :
                        (rx_size == TBDP_SZ_WORD) ? {22'h0, rx_word[9:1], 1'b0} :
                        {22'h0, rx_word[9:0]};
  assign cmd_is_wr = (cmd_data.opcode == TBDP_OP_WR_MEM) || (cmd_data.opcode == TBDP_OP_WR_CTL) ||
                     (cmd_data.opcode == TBDP_OP_WR_DBG);
  // Finished result replaces the queued word at the first rise of a frame
  assign rsp_word  = (resp_q == TBDP_RS_BERR) ? {1'b1, TBDP_RSP_BERR} : {1'b0, rdata_q[15:0]};
  assign tx_src    = (done_pend_q && bit_q == '0) ? rsp_word : tx_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_q      <= '0;
      tx_q      <= {1'b1, TBDP_RSP_ZERO};
      bit_q     <= '0;
      busy_q    <= 1'b0;
      berr_q    <= 1'b0;
      done_pend_q <= 1'b0;
      rdata_q   <= '0;
      resp_q    <= TBDP_RS_NRDY;
      cmd_valid <= 1'b0;
      cmd_data  <= '0;
      host_serial_out <= 1'b1;
    end else begin
      // Result offered once; a completion in the same cycle wins
      if (sclk_rise && bit_q == '0) begin
        done_pend_q <= 1'b0;
      end
      if (cmd_valid && cmd_done) begin
        cmd_valid   <= 1'b0;
        busy_q      <= 1'b0;
        done_pend_q <= 1'b1;
        berr_q      <= cmd_bus_error;
        rdata_q     <= cmd_is_wr ? {16'h0, TBDP_RSP_ALL1} :
                       (cmd_data.size == TBDP_SZ_BYTE) ? {24'h0, cmd_rdata[7:0]} : cmd_rdata;
        resp_q      <= cmd_bus_error ? TBDP_RS_BERR : TBDP_RS_OK;
      end
      if (sclk_rise) begin
        host_serial_out <= tx_src[16];
        tx_q            <= {tx_src[15:0], 1'b0};
        rx_q            <= {rx_q[15:0], sin_sync_q[1]};
        if (bit_q == TBDP_SER_LAST) begin
          bit_q <= '0;
          if (busy_q || done_pend_q) begin
            tx_q <= {1'b1, TBDP_RSP_ZERO};
          end else if (is_illegal) begin
            tx_q <= {1'b1, TBDP_RSP_ALL1};
          end else begin
            tx_q      <= {1'b1, TBDP_RSP_ZERO};
            cmd_valid <= 1'b1;
            busy_q    <= 1'b1;
            resp_q    <= TBDP_RS_NRDY;
            cmd_data  <= '{opcode: rx_op, size: rx_size, reg_sel: rx_word[11:0], addr: aligned_addr};
          end
        end else begin
          bit_q <= bit_q + 5'd1;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_take;
    buf_take;
  endsequence
  sequence s_announce;
    exec_status_nibble[3:2] == 2'b10;
  endsequence

  a_count_before_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_take |=> s_announce) else $error("count code missing");
  a_no_reserved_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    exec_status_nibble != 4'h2 && exec_status_nibble != 4'h6) else $error("reserved status");
  a_halt_held: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_mode == TBDP_MD_HALT |=> exec_status_nibble == TBDP_ST_HALT) else $error("halt not shown");
  a_stall_when_full: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_stall |-> held_q == 2'd2) else $error("stall without full buffer");
  a_no_stall_room: assert property (@(posedge clk_sys) disable iff (sys_rst)
    held_q < 2'd2 |-> !core_stall) else $error("needless stall");
  a_dso_on_clock: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sclk_rise |=> $stable(host_serial_out)) else $error("serial out moved");
  a_mark_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_mode == TBDP_MD_RUN && !buf_take && core_address_gen_execute_stage_first && core_event == TBDP_EV_MARK
      |=> exec_status_nibble == TBDP_ST_MARK) else $error("marker code wrong");
  a_branch_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_mode == TBDP_MD_RUN && !buf_take && core_address_gen_execute_stage_first && core_event == TBDP_EV_BRANCH
      |=> exec_status_nibble == TBDP_ST_BRANCH) else $error("branch code wrong");
  a_align_long: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_valid && cmd_data.size == TBDP_SZ_LONG |-> cmd_data.addr[1:0] == 2'b00) else $error("long not aligned");
  a_align_word: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_valid && cmd_data.size == TBDP_SZ_WORD |-> !cmd_data.addr[0]) else $error("word not aligned");
endmodule // tbdp_top

// ### design/tbdp_pkg.sv
// Summary of operation
// - Trace output is a 4-bit status nibble plus a separate 4-bit data nibble.
// - Status nibble changes only on clock edges; need not match current bus transfer.
// - Codes 0000 continue, 0001 instr, 0011 user, 0101 branch, 0111 exception return.
// - Codes 1000 to 1011 announce a one to four byte data transfer.
// - 1100 exception, 1101 emulator entry, 1110 stopped, 1111 halted.
// - Codes 1100..1111 held while mode lasts; others refresh every cycle.
// - Byte-count code appears one cycle before first data nibble.
// - Variant branch shows 0101, optional count, then 2, 3 or 4 address bytes; here the count comes from cap_data, branch_addr_bytes_m1 is unused.
// - Values shift out low nibble first, one per clock, core keeps running.
// - Two-entry 32-bit buffer captures branch targets and operand data.
// - Core stalls only while both entries are full, until one frees.
// - Instruction status shown in its first address-generate/execute cycle.
// - Trigger-marker instruction shows code 0100, shared with write-debug-value.
// - Write-debug-value instruction outputs operand always and shows 0100.
// - Serial controller separate; register commands need halted core, memory does not; fill and dump here also need a halted core.
// - Serial clock and input sampled on clock rises; output changes on rising edge.
// - Serial output changes only while serial clock is high.
// - Control register commands use move-to-control coding; debug registers separate.
// - Subroutine-call and target-reset unsupported; fill and dump may answer illegal.
// - Byte memory reads return data in low 8 bits, upper bits undefined.
// - Memory addresses forced to word/longword alignment; no address-error answer.
// - Each exchange is a 17-bit word; serial clock at most half system clock.
// - Answers: 0/FFFF complete, 1/0000 not ready, 1/0001 bus error, 1/FFFF illegal.
package tbdp_pkg;
  // ****************************************
  // Status codes
  // ****************************************
  typedef enum logic [3:0] {
    TBDP_ST_CONT   = 4'h0,
    TBDP_ST_INSTR  = 4'h1,
    TBDP_ST_USER   = 4'h3,
    TBDP_ST_MARK   = 4'h4,
    TBDP_ST_BRANCH = 4'h5,
    TBDP_ST_RETEX  = 4'h7,
    TBDP_ST_CNT1   = 4'h8,
    TBDP_ST_CNT2   = 4'h9,
    TBDP_ST_CNT3   = 4'ha,
    TBDP_ST_CNT4   = 4'hb,
    TBDP_ST_EXC    = 4'hc,
    TBDP_ST_EMU    = 4'hd,
    TBDP_ST_STOP   = 4'he,
    TBDP_ST_HALT   = 4'hf
  } tbdp_status_e;

  // Core event kinds on the trace side
  typedef enum logic [2:0] {
    TBDP_EV_NONE   = 3'h0,
    TBDP_EV_INSTR  = 3'h1,
    TBDP_EV_USER   = 3'h2,
    TBDP_EV_MARK   = 3'h3,
    TBDP_EV_BRANCH = 3'h4,
    TBDP_EV_RETEX  = 3'h5
  } tbdp_event_e;

  // Core long-lived modes
  typedef enum logic [2:0] {
    TBDP_MD_RUN  = 3'h0,
    TBDP_MD_EXC  = 3'h1,
    TBDP_MD_EMU  = 3'h2,
    TBDP_MD_STOP = 3'h3,
    TBDP_MD_HALT = 3'h4
  } tbdp_mode_e;

  // One captured value: data and byte count minus one
  typedef struct packed {
    logic [1:0]  nbytes_m1;
    logic [31:0] value;
  } tbdp_capture_s;

  localparam int TBDP_CAP_W   = 34;
  localparam int TBDP_FIFO_D  = 2;

  // ****************************************
  // Serial command port
  // ****************************************
  localparam int          TBDP_SER_BITS = 17;
  localparam logic [4:0]  TBDP_SER_LAST = 5'd16;
  localparam logic [15:0] TBDP_RSP_ALL1 = 16'hffff;
  localparam logic [15:0] TBDP_RSP_ZERO = 16'h0000;
  localparam logic [15:0] TBDP_RSP_BERR = 16'h0001;

  // Command opcode field, upper bits of the command word
  localparam logic [3:0] TBDP_OP_RD_MEM  = 4'h1;
  localparam logic [3:0] TBDP_OP_WR_MEM  = 4'h2;
  localparam logic [3:0] TBDP_OP_RD_CTL  = 4'h3;
  localparam logic [3:0] TBDP_OP_WR_CTL  = 4'h4;
  localparam logic [3:0] TBDP_OP_RD_DBG  = 4'h5;
  localparam logic [3:0] TBDP_OP_WR_DBG  = 4'h6;
  localparam logic [3:0] TBDP_OP_FILL    = 4'h7;
  localparam logic [3:0] TBDP_OP_DUMP    = 4'h8;
  localparam logic [3:0] TBDP_OP_CALL    = 4'h9;
  localparam logic [3:0] TBDP_OP_RST     = 4'ha;
  localparam logic [1:0] TBDP_SZ_BYTE    = 2'h0;
  localparam logic [1:0] TBDP_SZ_WORD    = 2'h1;
  localparam logic [1:0] TBDP_SZ_LONG    = 2'h2;

  typedef enum logic [1:0] {
    TBDP_RS_OK    = 2'h0,
    TBDP_RS_NRDY  = 2'h1,
    TBDP_RS_BERR  = 2'h2,
    TBDP_RS_ILL   = 2'h3
  } tbdp_resp_e;

  // Decoded command towards the core side
  typedef struct packed {
    logic [3:0]  opcode;
    logic [1:0]  size;
    logic [11:0] reg_sel;
    logic [31:0] addr;
  } tbdp_cmd_s;
endpackage

// ### design/tbdp_fifo.sv
`timescale 1ns/100ps
module tbdp_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("tbdp_fifo: bad size");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH)) || out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule // tbdp_fifo

// ### tb/tbdp_host_model.sv
`timescale 1ns/100ps
module tbdp_host_model (
  input  wire logic        clk_sys,
  input  wire logic        go,
  input  wire logic [16:0] tx_word,
  input  wire logic        host_serial_out,
  output logic             host_serial_clock,
  output logic             host_serial_in,
  output logic             busy,
  output logic [16:0]      rx_word
);
  logic [16:0] w;

  // Serial clock stands low between frames; idle data shows inverse of last bit
  initial begin
    host_serial_clock = 1'b0;
    host_serial_in    = 1'b0;
    busy              = 1'b0;
    rx_word           = '0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        w = tx_word;
        busy <= 1'b1;
        for (int i = 16; i >= 0; i--) begin
          host_serial_in <= w[i];
          repeat (8) @(posedge clk_sys);
          host_serial_clock <= 1'b1;
          repeat (8) @(posedge clk_sys);
          // Output has settled while the clock is high
          rx_word[i] = host_serial_out;
          host_serial_clock <= 1'b0;
        end
        host_serial_in <= ~w[0];
        busy <= 1'b0;
      end
    end
  end
endmodule // tbdp_host_model

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import tbdp_pkg::*;
  logic          clk_sys = 1'b0;
  logic          sys_rst = 1'b1;
  tbdp_event_e   core_event = TBDP_EV_NONE;
  tbdp_mode_e    core_mode = TBDP_MD_RUN;
  logic          core_address_gen_execute_stage_first = 1'b0;
  logic          cap_valid = 1'b0;
  tbdp_capture_s cap_data = '0;
  logic          cmd_done = 1'b0;
  logic          cmd_bus_error = 1'b0;
  logic [31:0]   cmd_rdata = '0;
  logic          go = 1'b0;
  logic [16:0]   tx_word = '0;
  logic          core_stall, cmd_valid, host_serial_clock, host_serial_in, host_serial_out, busy;
  logic [3:0]    exec_status_nibble, debug_value_nibble;
  tbdp_cmd_s     cmd_data, last_cmd, first_cmd;
  logic [16:0]   rx_word, rsp;
  logic [31:0]   acc;
  logic [31:0]   rxq[$];
  int            rsp_lim = 3;
  int            rsp_cnt = 0;
  int            rem = 0;
  int            nib = 0;
  int            error_cnt = 0;
  int            compares = 0;

  tbdp_top #(.FIFO_DEPTH(8)) tbdp_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_event(core_event),
    .core_mode(core_mode), .core_address_gen_execute_stage_first(core_address_gen_execute_stage_first), .branch_addr_bytes_m1(2'h1),
    .cap_valid(cap_valid), .cap_data(cap_data), .core_stall(core_stall),
    .exec_status_nibble(exec_status_nibble), .debug_value_nibble(debug_value_nibble),
    .host_serial_clock(host_serial_clock), .host_serial_in(host_serial_in), .host_serial_out(host_serial_out),
    .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_done(cmd_done), .cmd_bus_error(cmd_bus_error),
    .cmd_rdata(cmd_rdata), .cmd_wdata_unused(16'h0000));

  tbdp_host_model tbdp_host_model_i (.clk_sys(clk_sys), .go(go), .tx_word(tx_word),
    .host_serial_out(host_serial_out), .host_serial_clock(host_serial_clock),
    .host_serial_in(host_serial_in), .busy(busy), .rx_word(rx_word));

  always #5 clk_sys = ~clk_sys;

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("Mismatches %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Collects data nibbles announced by a byte-count code
  always @(posedge clk_sys) begin
    if (!sys_rst) begin
      check(32'(exec_status_nibble == 4'h2 || exec_status_nibble == 4'h6), 32'h0, "reserved code");
      if (rem > 0) begin
        acc[nib*4 +: 4] = debug_value_nibble;
        nib++;
        rem--;
        if (rem == 0)
          rxq.push_back(acc);
      end
      if (exec_status_nibble[3:2] == 2'b10) begin
        check(32'(rem), 32'h0, "count code during data");
        rem = 2 * (exec_status_nibble[1:0] + 1);
        nib = 0;
        acc = '0;
      end
    end
  end

  // Memory side answers after a settable delay
  always @(posedge clk_sys) begin
    cmd_done <= 1'b0;
    if (cmd_valid && !cmd_done) begin
      last_cmd <= cmd_data;
      rsp_cnt <= rsp_cnt + 1;
      if (rsp_cnt >= rsp_lim) begin
        cmd_done <= 1'b1;
        rsp_cnt <= 0;
      end
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_events;
    tbdp_event_e  ev[5] = '{TBDP_EV_INSTR, TBDP_EV_USER, TBDP_EV_MARK, TBDP_EV_BRANCH, TBDP_EV_RETEX};
    tbdp_status_e st[5] = '{TBDP_ST_INSTR, TBDP_ST_USER, TBDP_ST_MARK, TBDP_ST_BRANCH, TBDP_ST_RETEX};
    tbdp_mode_e   md[4] = '{TBDP_MD_EXC, TBDP_MD_EMU, TBDP_MD_STOP, TBDP_MD_HALT};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      core_event <= ev[i];
      core_address_gen_execute_stage_first <= 1'b1;
      @(posedge clk_sys);
      core_address_gen_execute_stage_first <= 1'b0;
      core_event <= TBDP_EV_NONE;
      #1 check(exec_status_nibble, st[i], "event code");
      @(posedge clk_sys);
      #1 check(exec_status_nibble, TBDP_ST_CONT, "code refreshed");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      core_mode <= md[i];
      repeat (2) @(posedge clk_sys);
      #1 check(exec_status_nibble, 32'hc + i, "mode code");
      repeat (6) @(posedge clk_sys);
      #1 check(exec_status_nibble, 32'hc + i, "mode code held");
    end
    @(posedge clk_sys);
    core_mode <= TBDP_MD_RUN;
  endtask

  task automatic t_capture;
    for (int n = 0; n < 4; n++) begin
      rxq.delete();
      @(posedge clk_sys);
      cap_valid <= 1'b1;
      cap_data <= {2'(n), 32'h8765_4321};
      @(posedge clk_sys);
      cap_valid <= 1'b0;
      repeat (14) @(posedge clk_sys);
      #1 check(32'(rxq.size()), 32'h1, "words out");
      check(rxq.pop_front(), 32'h8765_4321 & ~(32'hffff_ffff << (8 * (n + 1))), "word value");
      check(32'(core_stall), 32'h0, "no stall");
    end
  endtask

  task automatic t_stall;
    int   k;
    logic stl;
    logic saw;
    k = 0;
    saw = 1'b0;
    rxq.delete();
    @(posedge clk_sys);
    cap_valid <= 1'b1;
    cap_data <= {2'h3, 32'h1111_1111};
    while (k < 4) begin
      #1 stl = core_stall;
      if (k < 2)
        check(32'(stl), 32'h0, "stall with free entry");
      saw = saw | stl;
      @(posedge clk_sys);
      if (!stl) begin
        k++;
        cap_data <= {2'h3, 32'(32'h1111_1111 * (k + 1))};
      end
    end
    cap_valid <= 1'b0;
    check(32'(saw), 32'h1, "stall when full");
    repeat (50) @(posedge clk_sys);
    #1 check(32'(rxq.size()), 32'h4, "buffered words");
    for (int i = 1; i <= 4; i++)
      check(rxq.pop_front(), 32'(32'h1111_1111 * i), "buffer order");
  endtask

  task automatic xfer(input logic [3:0] op, input logic [1:0] sz, input logic [9:0] ad);
    @(posedge clk_sys);
    tx_word <= {1'b0, op, sz, ad};
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy)
      @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic cmd_rsp(input logic [3:0] op, input logic [1:0] sz, input logic [9:0] ad);
    xfer(op, sz, ad);
    first_cmd = last_cmd;
    xfer(TBDP_OP_RD_MEM, TBDP_SZ_BYTE, 10'h000);
    rsp = rx_word;
  endtask

  task automatic t_serial;
    logic [3:0] ill[6] = '{TBDP_OP_CALL, TBDP_OP_RST, TBDP_OP_FILL, TBDP_OP_DUMP, TBDP_OP_RD_CTL, TBDP_OP_WR_CTL};
    foreach (ill[i]) begin
      cmd_rsp(ill[i], TBDP_SZ_WORD, 10'h004);
      check(rsp, 17'h1ffff, "illegal answer");
    end
    cmd_rdata <= 32'h1234_56a5;
    cmd_rsp(TBDP_OP_RD_MEM, TBDP_SZ_BYTE, 10'h013);
    check({rsp[16], rsp[7:0]}, 9'h0a5, "byte read");
    cmd_rsp(TBDP_OP_RD_MEM, TBDP_SZ_LONG, 10'h3ff);
    check(first_cmd.addr, 32'h0000_03fc, "long aligned");
    cmd_bus_error <= 1'b1;
    cmd_rsp(TBDP_OP_RD_MEM, TBDP_SZ_WORD, 10'h001);
    check(rsp, 17'h10001, "bus error answer");
    check(first_cmd.addr, 32'h0000_0000, "word aligned");
    cmd_bus_error <= 1'b0;
    rsp_lim = 400;
    cmd_rsp(TBDP_OP_RD_MEM, TBDP_SZ_BYTE, 10'h002);
    check(rsp, 17'h10000, "not ready answer");
    repeat (600) @(posedge clk_sys);
    rsp_lim = 3;
    core_mode <= TBDP_MD_HALT;
    cmd_rsp(TBDP_OP_RD_CTL, TBDP_SZ_LONG, 10'h005);
    check(first_cmd.opcode, TBDP_OP_RD_CTL, "control read runs");
    cmd_rsp(TBDP_OP_WR_DBG, TBDP_SZ_LONG, 10'h001);
    check(rsp, 17'h0ffff, "complete answer");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    #1 check({exec_status_nibble, debug_value_nibble, host_serial_out, cmd_valid, core_stall}, 32'h4, "reset");
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_events();
    t_capture();
    t_stall();
    t_serial();
    tally_and_finish();
  end

  initial begin
    #400us;
    error_cnt++;
    tally_and_finish();
  end
endmodule // testbench
